//--- rtl/hbp_port.sv
// Parallel host port: address latch, register file, read latch, interrupt pin
//
// What this block does
// R01 - Drive interrupt low when a flagged status bit is enabled by its mask.
// R02 - Hold interrupt asserted until host finishes reading the status register.
// R03 - After that read, float interrupt unless a new event arrived during it.
// R04 - Four address lines pick the register, line zero is least significant.
// R05 - Muxed host holds address stable before latch strobe falls.
// R06 - Non-muxed host ties latch strobe high and holds address whole access.
// R07 - Eight-bit bidirectional non-inverting tristate bus, direction by strobes.
// R08 - Muxed host puts address on low data lines with the latch strobe.
// R09 - Data bus floats whenever chip select is inactive.
// R10 - Board ties address inputs to low data lines in muxed operation.
// R11 - Host drives data while select and write low; captured on write rise.
// R12 - Device drives addressed register while select and read are low.
// R13 - Register access only while chip select is low.
// R14 - Address latch transparent while strobe high, holds on falling edge.
// R15 - Reset pin low floats every output and loads register defaults.
// R16 - After reset rises, stay partly reset until a frame-sync pulse.
// R17 - Registers occupy sixteen consecutive host addresses.
// R18 - Read data is latched at read start, later changes do not reach bus.
// R19 - Status bits set whatever the mask; masks only gate the pin.
// R20 - Location fifteen is read-only status; completed read clears the bits it returned.
// R21 - Host strobes synchronised to the clock before updating any state.
`timescale 1ns/1ps
`default_nettype none
module hbp_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale,
  input wire logic [hbp_pkg::ADDR_W-1:0] reg_select_lines,
  input wire logic [hbp_pkg::DATA_W-1:0] muxed_addr_data_bus_in,
  output logic [hbp_pkg::DATA_W-1:0] muxed_addr_data_bus_out,
  output logic muxed_addr_data_bus_oe,
  output logic irq_n_out,
  output logic irq_n_oe,
  input wire logic reset_n,
  input wire logic frame_sync_pulse,
  input wire logic [hbp_pkg::NUM_IRQ-1:0] irq_events,
  output logic [hbp_pkg::DATA_W-1:0] wr_data,
  output logic [hbp_pkg::ADDR_W-1:0] wr_addr,
  output logic wr_pulse,
  output logic fully_released
);
  import hbp_pkg::*;

  hbp_sync_if sif ();

  // All host pins cross through two flops first; irq_events goes straight to status (see R21)
  hbp_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .cs_n(cs_n),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .ale(ale),
    .reg_select_lines(reg_select_lines),
    .bus_in(muxed_addr_data_bus_in),
    .reset_n(reset_n),
    .frame_sync_pulse(frame_sync_pulse),
    .s(sif)
  );

  // Decode helper used for both read and write hits
  function automatic logic is_status(input logic [ADDR_W-1:0] a);
    return a == STATUS_ADDR;
  endfunction

  hbp_state_t state;
  hbp_state_t next_state;
  logic [ADDR_W-1:0] addr_latch;
  logic [ADDR_W-1:0] next_addr_latch;
  logic [DATA_W-1:0] regs [NUM_REGS];
  logic [DATA_W-1:0] next_regs [NUM_REGS];
  logic [NUM_IRQ-1:0] status;
  logic [NUM_IRQ-1:0] next_status;
  logic [NUM_IRQ-1:0] rd_snap;
  logic [NUM_IRQ-1:0] next_rd_snap;
  logic [DATA_W-1:0] rd_hold;
  logic [DATA_W-1:0] next_rd_hold;
  logic [DATA_W-1:0] wdat;
  logic [DATA_W-1:0] next_wdat;
  logic released;
  logic next_released;
  logic wpulse;
  logic next_wpulse;
  logic [DATA_W-1:0] next_bus_out;
  logic next_bus_oe;
  logic next_irq_oe;
  logic [ADDR_W-1:0] addr_mux;
  logic rd_act;
  logic wr_act;

  // Pass-through address while strobe high; muxed hosts wire pins to AD (see R14)
  assign addr_mux = sif.ale ? sif.addr_pins : addr_latch; // see R04
  assign rd_act = !sif.cs_n && !sif.rd_n; // see R13
  assign wr_act = !sif.cs_n && !sif.wr_n;

  // Next-state for access, registers, status and pins
  always_comb begin
    next_state = state;
    next_addr_latch = addr_mux; // see R14
    next_regs = regs;
    next_status = status | irq_events; // set regardless of mask, see R19
    next_rd_snap = rd_snap;
    next_rd_hold = rd_hold;
    next_wdat = wdat;
    next_wpulse = 1'b0;
    next_released = released;
    next_bus_out = muxed_addr_data_bus_out;
    next_bus_oe = 1'b0;
    if (sif.fs && sif.rst_n) begin
      next_released = 1'b1; // see R16
    end
    unique case (state)
      HBP_IDLE: begin
        if (rd_act) begin
          next_state = HBP_READ;
          // Snapshot so later changes during the cycle stay off the bus (see R18)
          if (is_status(addr_mux)) begin
            next_rd_hold = {{(DATA_W-NUM_IRQ){1'b0}}, status};
            next_rd_snap = status;
          end else begin
            next_rd_hold = regs[addr_mux]; // see R17
            next_rd_snap = IRQ_ZERO;
          end
        end else if (wr_act) begin
          next_state = HBP_WRITE;
        end
      end
      HBP_READ: begin
        next_bus_oe = rd_act; // see R12
        next_bus_out = rd_hold;
        if (!rd_act) begin
          next_state = HBP_IDLE;
          // Clear only what was read; new events during read survive (see R20)
          next_status = (status & ~rd_snap) | irq_events; // see R03
          next_rd_snap = IRQ_ZERO;
        end
      end
      HBP_WRITE: begin
        next_wdat = sif.data_in;
        if (!wr_act) begin
          // Capture on the strobe's rising edge, status is read-only (see R11)
          next_state = HBP_IDLE;
          next_wpulse = !is_status(addr_latch);
          if (!is_status(addr_latch)) begin
            next_regs[addr_latch] = wdat;
          end
        end
      end
      default: next_state = HBP_IDLE;
    endcase
    // Chip select gone or reset pin low floats the bus (see R09)
    if (sif.cs_n || !sif.rst_n) begin
      next_bus_oe = 1'b0; // see R15
    end
    // Pin low while any enabled flag pends; otherwise float (see R01)
    next_irq_oe = sif.rst_n && |(next_status & regs[MASK_ADDR][NUM_IRQ-1:0]); // see R02
    // Reset pin loads defaults and drops release until next frame sync
    if (!sif.rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        next_regs[i] = REG_RESET; // see R15
      end
      next_status = IRQ_ZERO;
      next_released = 1'b0; // see R16
      next_state = HBP_IDLE;
      next_wpulse = 1'b0;
    end
  end

  // State registers, frozen when clock enable is low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= HBP_IDLE;
      addr_latch <= ADDR_ZERO;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET;
      end
      status <= IRQ_ZERO;
      rd_snap <= IRQ_ZERO;
      rd_hold <= DATA_ZERO;
      wdat <= DATA_ZERO;
      wpulse <= 1'b0;
      released <= 1'b0;
      muxed_addr_data_bus_out <= DATA_ZERO;
      muxed_addr_data_bus_oe <= 1'b0;
      irq_n_oe <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      addr_latch <= next_addr_latch;
      regs <= next_regs;
      status <= next_status;
      rd_snap <= next_rd_snap;
      rd_hold <= next_rd_hold;
      wdat <= next_wdat;
      wpulse <= next_wpulse;
      released <= next_released;
      muxed_addr_data_bus_out <= next_bus_out; // see R07
      muxed_addr_data_bus_oe <= next_bus_oe;
      irq_n_oe <= next_irq_oe;
    end
  end

  // Open-drain style: level is always low, enable does the work
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_n_out <= 1'b0;
      wr_data <= DATA_ZERO;
      wr_addr <= ADDR_ZERO;
      wr_pulse <= 1'b0;
      fully_released <= 1'b0;
    end else if (clk_en) begin
      irq_n_out <= 1'b0;
      wr_data <= wdat;
      wr_addr <= addr_latch;
      wr_pulse <= wpulse;
      fully_released <= released;
    end
  end
endmodule
`default_nettype wire

//--- rtl/hbp_pkg.sv
// Package: constants and types for the host bus port
package hbp_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 16;
  localparam int NUM_IRQ = 4;
  localparam logic [3:0] STATUS_ADDR = 4'hF;
  localparam logic [3:0] MASK_ADDR = 4'h7;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 4'h0;
  localparam logic [NUM_IRQ-1:0] IRQ_ZERO = 4'h0;
  // Status bits 3:0 are the sticky flags, mask bits 3:0 enable them
  localparam int IRQ_LSB = 0;
  typedef enum logic [1:0] {
    HBP_IDLE = 2'b00,
    HBP_READ = 2'b01,
    HBP_WRITE = 2'b10
  } hbp_state_t;
endpackage

//--- rtl/hbp_sync_if.sv
// Interface: synchronised host strobes and address between sync and core
`timescale 1ns/1ps
`default_nettype none
interface hbp_sync_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic ale;
  logic [3:0] addr_pins;
  logic [3:0] ad_low;
  logic [7:0] data_in;
  logic rst_n;
  logic fs;
  modport src (output cs_n, rd_n, wr_n, ale, addr_pins, ad_low, data_in, rst_n, fs);
  modport dst (input cs_n, rd_n, wr_n, ale, addr_pins, ad_low, data_in, rst_n, fs);
endinterface
`default_nettype wire

//--- rtl/hbp_sync.sv
// Two-flop synchroniser for every host pin entering the clock domain
`timescale 1ns/1ps
`default_nettype none
module hbp_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale,
  input wire logic [3:0] reg_select_lines,
  input wire logic [7:0] bus_in,
  input wire logic reset_n,
  input wire logic frame_sync_pulse,
  hbp_sync_if.src s
);
  import hbp_pkg::*;
  localparam int W = 24;
  // Strobes and latch enable idle high; device reset and frame sync idle low
  localparam logic [W-1:0] SYNC_IDLE = 24'hF00000;
  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_stable;

  // Strobes idle high so reset to ones; first stage only feeds second
  always_comb begin
    next_meta = meta;
    next_stable = stable;
    if (clk_en) begin
      next_meta = {cs_n, rd_n, wr_n, ale, reg_select_lines, bus_in[3:0], bus_in,
                   reset_n, frame_sync_pulse, 2'b00};
      next_stable = meta;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= SYNC_IDLE;
      stable <= SYNC_IDLE;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
    end
  end

  assign s.cs_n = stable[23];
  assign s.rd_n = stable[22];
  assign s.wr_n = stable[21];
  assign s.ale = stable[20];
  assign s.addr_pins = stable[19:16];
  assign s.ad_low = stable[15:12];
  assign s.data_in = stable[11:4];
  assign s.rst_n = stable[3];
  assign s.fs = stable[2];
endmodule
`default_nettype wire

//--- bench/hbp_port_chk.sv
// Concurrent checks on the host bus port pins
`timescale 1ns/1ps
`default_nettype none
module hbp_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale,
  input wire logic reset_n,
  input wire logic [hbp_pkg::ADDR_W-1:0] reg_select_lines,
  input wire logic [hbp_pkg::DATA_W-1:0] muxed_addr_data_bus_out,
  input wire logic muxed_addr_data_bus_oe,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic wr_pulse,
  input wire logic [hbp_pkg::ADDR_W-1:0] wr_addr
);
  import hbp_pkg::*;
  logic [3:0] quiet;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Cycles since a read or a device reset; saturates so it never wraps back
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      quiet <= 4'hF;
    end else if ((!cs_n && !rd_n) || !reset_n) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end
  sequence rd_held;
    (!cs_n && !rd_n && reset_n) [*6];
  endsequence
  sequence wr_done;
    !cs_n && ale && $rose(wr_n) && reg_select_lines != STATUS_ADDR;
  endsequence
  bus_float_a: assert property (cs_n [*5] |-> !muxed_addr_data_bus_oe)
    else $error("data bus driven without chip select");
  rd_drive_a: assert property (rd_held |-> muxed_addr_data_bus_oe)
    else $error("read not driven onto bus");
  oe_cause_a: assert property (muxed_addr_data_bus_oe |-> quiet < 4'h5)
    else $error("bus driven with no read");
  read_stable_a: assert property (muxed_addr_data_bus_oe &&
    $past(muxed_addr_data_bus_oe) |-> $stable(muxed_addr_data_bus_out))
    else $error("read data changed during read");
  wr_taken_a: assert property (wr_done |-> ##[3:5] wr_pulse)
    else $error("write not taken");
  status_ro_a: assert property (wr_pulse |-> wr_addr != STATUS_ADDR)
    else $error("status register written");
  irq_level_a: assert property (!irq_n_out)
    else $error("interrupt pin drives high");
  irq_hold_a: assert property ($fell(irq_n_oe) |-> quiet < 4'h6)
    else $error("interrupt dropped without status read");
  reset_float_a: assert property (!reset_n [*5] |->
    !muxed_addr_data_bus_oe && !irq_n_oe)
    else $error("outputs driven in device reset");
endmodule
bind hbp_port hbp_chk u_chk (.*);
`default_nettype wire

//--- bench/hbp_host.sv
// Host processor model on the port pins
`timescale 1ns/1ps
`default_nettype none
module hbp_host (
  input wire logic clk,
  input wire logic dev_oe,
  input wire logic [7:0] dev_out,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic ale,
  output logic [3:0] sel,
  output logic [7:0] lvl
);
  logic drv = 1'b0;
  logic mux = 1'b0;
  logic cs = 1'b1;
  logic csoff = 1'b0;
  logic [7:0] dd = 8'h00;
  logic [3:0] a = 4'h0;
  // Released bus shows the inverse of the last value, never a held copy
  assign lvl = dev_oe ? dev_out : (drv ? dd : ~dd);
  // Select pins strapped to the low bus lines in muxed mode
  assign sel = mux ? lvl[3:0] : a;
  assign cs_n = cs | csoff;
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    ale = 1'b1;
  end
  // Address held across the latch strobe fall; strobe stays high unmuxed
  task automatic addr(input logic [3:0] ad);
    @(negedge clk);
    a = ad;
    dd = {4'h0, ad};
    drv = mux;
    ale = 1'b1;
    @(negedge clk);
    ale = !mux;
    @(negedge clk);
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    addr(ad);
    dd = d;
    drv = 1'b1;
    cs = 1'b0;
    wr_n = 1'b0;
    repeat (4) @(negedge clk);
    wr_n = 1'b1;
    @(negedge clk);
    cs = 1'b1;
    drv = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  task automatic rd_start(input logic [3:0] ad);
    addr(ad);
    drv = 1'b0;
    cs = 1'b0;
    rd_n = 1'b0;
  endtask
  // Returns the enable beside the data so a floating bus is caught
  task automatic rd_end(output logic [8:0] r);
    repeat (6) @(negedge clk);
    r = {dev_oe, lvl};
    rd_n = 1'b1;
    @(negedge clk);
    cs = 1'b1;
    repeat (6) @(negedge clk);
  endtask
endmodule
`default_nettype wire

//--- bench/hbp_port_test.sv
// Self-checking bench for the host bus port
`timescale 1ns/1ps
`default_nettype none
module hbp_port_test;
  import hbp_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_n = 1'b0;
  logic fs = 1'b0;
  logic cs_n, rd_n, wr_n, ale, oe, ion, ioe, wp, rel;
  logic [3:0] sel, wa, pa;
  logic [3:0] ev = 4'h0;
  logic [7:0] lvl, dout, wd, pd;
  logic [8:0] r;
  int n_fail = 0;
  int checks_done = 0;
  int npulse = 0;
  always #25 clk = ~clk;
  hbp_port DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .ale(ale), .reg_select_lines(sel), .muxed_addr_data_bus_in(lvl),
    .muxed_addr_data_bus_out(dout), .muxed_addr_data_bus_oe(oe), .irq_n_out(ion),
    .irq_n_oe(ioe), .reset_n(reset_n), .frame_sync_pulse(fs), .irq_events(ev),
    .wr_data(wd), .wr_addr(wa), .wr_pulse(wp), .fully_released(rel));
  hbp_host u_host (.clk(clk), .dev_oe(oe), .dev_out(dout), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .ale(ale), .sel(sel), .lvl(lvl));
  // Pulses are one cycle wide, so they are counted here rather than polled
  // Sampled between edges, where the flopped pulse has settled
  always @(negedge clk) if (wp === 1'b1) begin
    npulse++;
    pa = wa;
    pd = wd;
  end
  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic take);
    int n0;
    n0 = npulse;
    u_host.wr(a, d);
    chk("write pulses", {8'h0, take}, 9'(npulse - n0));
    if (take) chk("write addr", {5'h0, a}, {5'h0, pa});
    if (take) chk("write data", {1'b0, d}, {1'b0, pd});
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    u_host.rd_start(a);
    u_host.rd_end(r);
    chk("read", {1'b1, exp}, r);
  endtask
  task automatic pulse(input logic [3:0] b);
    @(negedge clk);
    ev = b;
    @(negedge clk);
    ev = 4'h0;
  endtask
  task automatic t_reset();
    chk("reset float", 9'h0, {6'h0, oe, ioe, rel});
    reset_n = 1'b1;
    repeat (6) @(negedge clk);
    chk("partly reset", 9'h0, {8'h0, rel});
    fs = 1'b1;
    repeat (2) @(negedge clk);
    fs = 1'b0;
    repeat (20) if (rel !== 1'b1) @(negedge clk);
    chk("released", 9'h1, {8'h0, rel});
    if (rel !== 1'b1) final_report();
  endtask
  task automatic t_regs();
    for (int a = 0; a < 16; a++) wr(4'(a), {~4'(a), 4'(a)}, a != 15);
    for (int a = 0; a < 15; a++) rd(4'(a), {~4'(a), 4'(a)});
    rd(STATUS_ADDR, 8'h00);
  endtask
  task automatic t_mux_cs();
    u_host.mux = 1'b1;
    wr(4'h3, 8'h5A, 1'b1);
    rd(4'h3, 8'h5A);
    u_host.mux = 1'b0;
    u_host.csoff = 1'b1;
    wr(4'h3, 8'hC3, 1'b0);
    u_host.rd_start(4'h3);
    u_host.rd_end(r);
    chk("no select float", 9'h0, {8'h0, r[8]});
    u_host.csoff = 1'b0;
    rd(4'h3, 8'h5A);
  endtask
  task automatic t_irq();
    wr(MASK_ADDR, 8'h00, 1'b1);
    pulse(4'h2);
    repeat (3) @(negedge clk);
    chk("masked irq", 9'h0, {8'h0, ioe});
    rd(STATUS_ADDR, 8'h02);
    rd(STATUS_ADDR, 8'h00);
    wr(MASK_ADDR, 8'h0F, 1'b1);
    pulse(4'h1);
    repeat (10) @(negedge clk);
    chk("irq held", 9'h1, {8'h0, ioe});
    u_host.rd_start(STATUS_ADDR);
    repeat (4) @(negedge clk);
    pulse(4'h8);
    u_host.rd_end(r);
    chk("read snapshot", 9'h101, r);
    chk("irq kept", 9'h1, {8'h0, ioe});
    rd(STATUS_ADDR, 8'h08);
    chk("irq freed", 9'h0, {8'h0, ioe});
  endtask
  // Device reset in mid-run drops a pending interrupt and loads defaults again
  task automatic t_dev_reset();
    pulse(4'h4);
    repeat (3) @(negedge clk);
    chk("irq pending", 9'h1, {8'h0, ioe});
    reset_n = 1'b0;
    repeat (5) @(negedge clk);
    t_reset();
    rd(MASK_ADDR, 8'h00);
    rd(STATUS_ADDR, 8'h00);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_regs();
    t_mux_cs();
    t_irq();
    t_dev_reset();
    final_report();
  end
endmodule
`default_nettype wire
